/* File: logic/cfg_sysref_defines.svh */
// register offsets, field positions and reset values for the configuration bank
// assumes a byte-wide serial register port with 15-bit addresses
//
// Contract
// - mode field 0 normal, 3 full power down; 1 and 2 reserved.
// - 16-bit read-only identification always returns fixed maker code.
// - address-freeze set keeps streaming address constant every byte.
// - address-freeze clear lets direction bit choose ascend or descend.
// - direction one increments address per byte, zero decrements.
// - clock control bit 5 enables sysref receiver, default off.
// - clock control bit 6 enables sysref processor, default off, events ignored; the code also requires bit 5 set.
// - zoom bit 4 selects fine delay steps for position and selection.
// - sysref sampled with delay chosen by 4-bit selection field.
// - 24-bit read-only status reports sysref edge position across delays.
`ifndef CFG_SYSREF_DEFINES_SVH
`define CFG_SYSREF_DEFINES_SVH

`define ADDR_W 15
`define OFS_DIRECTION 15'h0000
`define OFS_POWER_MODE 15'h0002
`define OFS_MAKER_LO 15'h000C
`define OFS_MAKER_HI 15'h000D
`define OFS_USER_OPTIONS 15'h0010
`define OFS_CLOCK_CONTROL 15'h0029
`define OFS_EDGE_POS0 15'h002C
`define OFS_EDGE_POS1 15'h002D
`define OFS_EDGE_POS2 15'h002E

`define RST_DIRECTION 8'h30
`define RST_POWER_MODE 8'h00
`define RST_USER_OPTIONS 8'h00
`define RST_CLOCK_CONTROL 8'h80
// arbitrary neutral identification value
`define MAKER_CODE_VAL 16'h5AA5

`define BIT_ASCEND 5
`define BIT_RESET_REQ 7
`define BIT_FREEZE 0
`define BIT_PROC_EN 6
`define BIT_RECV_EN 5
`define BIT_ZOOM 4
`define MODE_POWER_DOWN 2'h3

`endif

/* File: logic/cfg_sysref_pkg.sv */
// types for the configuration bank
// shared by the register block, the host model and the bench
package cfg_sysref_pkg;
	typedef struct packed {
		logic [14:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
		logic start;
	} reg_req_t;

	typedef struct packed {
		logic recv_en;
		logic proc_en;
		logic zoom;
		logic [3:0] delay;
	} sysref_ctl_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_STREAM = 2'b10
	} stream_st_t;
endpackage

/* File: logic/cfg_sysref_regs.sv */
// configuration register bank with streaming address sequencer and sysref controls
// assumes the serial deframer gives one byte request per cycle, synchronous to sys_clk;
// start marks the first byte of a transfer and carries the host address
`timescale 1ns/1ps
`include "cfg_sysref_defines.svh"

module cfg_sysref_regs
	import cfg_sysref_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire reg_req_t req,
	input wire logic sysref_event,
	input wire logic [23:0] edge_position,
	output logic [7:0] rdata,
	output logic [14:0] cur_addr,
	output logic power_down,
	output sysref_ctl_t applied_ctl,
	output logic sysref_capture
);

	////////////////////////////////////////////////////////////////////////////////
	// storage
	logic [7:0] direction_q, direction_d;
	logic [7:0] power_mode_q, power_mode_d;
	logic [7:0] user_options_q, user_options_d;
	logic [7:0] clock_control_q, clock_control_d;
	logic [14:0] addr_q, addr_d;
	stream_st_t state_q, state_d;
	logic [7:0] rdata_q;
	logic power_down_q;
	sysref_ctl_t applied_q;
	logic capture_q;
	logic soft_reset_q;

	////////////////////////////////////////////////////////////////////////////////
	// address sequencing
	function automatic logic [14:0] next_addr(input logic [14:0] a, input logic frz,
		input logic up);
		next_addr = frz ? a : (up ? a + 15'h0001 : a - 15'h0001);
	endfunction

	wire logic active = req.wr | req.rd;
	wire logic freeze = user_options_q[`BIT_FREEZE];
	wire logic ascend = direction_q[`BIT_ASCEND];
	// first byte uses host address, later bytes stream from the previous one
	wire logic [14:0] eff_addr = req.start ? req.addr :
		next_addr(addr_q, freeze, ascend);
	wire logic wr_dir = req.wr && eff_addr == `OFS_DIRECTION;
	wire logic wr_pwr = req.wr && eff_addr == `OFS_POWER_MODE;
	wire logic wr_usr = req.wr && eff_addr == `OFS_USER_OPTIONS;
	wire logic wr_clk = req.wr && eff_addr == `OFS_CLOCK_CONTROL;

	always_comb begin
		state_d = state_q;
		addr_d = addr_q;
		if (active) begin
			state_d = ST_STREAM;
			addr_d = eff_addr;
		end else if (req.start) begin
			state_d = ST_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register writes; the maker word has no write path at all
	assign direction_d = wr_dir ? (req.wdata & 8'hEF) | 8'h10 : direction_q;
	assign power_mode_d = wr_pwr ? req.wdata : power_mode_q;
	assign user_options_d = wr_usr ? req.wdata : user_options_q;
	assign clock_control_d = wr_clk ? req.wdata : clock_control_q;

	// reserved bits are stored as written, except direction bit 4, which a write forces to one
	wire logic [7:0] dir_read = {1'b0, direction_q[6:0]};

	wire logic [7:0] rd_mux =
		eff_addr == `OFS_DIRECTION ? dir_read :
		eff_addr == `OFS_POWER_MODE ? power_mode_q :
		eff_addr == `OFS_MAKER_LO ? 8'(`MAKER_CODE_VAL) :
		eff_addr == `OFS_MAKER_HI ? 8'(`MAKER_CODE_VAL >> 8) :
		eff_addr == `OFS_USER_OPTIONS ? user_options_q :
		eff_addr == `OFS_CLOCK_CONTROL ? clock_control_q :
		eff_addr == `OFS_EDGE_POS0 ? edge_position[7:0] :
		eff_addr == `OFS_EDGE_POS1 ? edge_position[15:8] :
		eff_addr == `OFS_EDGE_POS2 ? edge_position[23:16] :
		8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// sysref controls
	wire logic recv_en = clock_control_q[`BIT_RECV_EN];
	// processor runs only behind an enabled receiver, which the host sets first
	wire logic proc_en = clock_control_q[`BIT_PROC_EN] & recv_en;
	// zoom and delay latch on a captured event so they take effect at the next one
	wire logic take_event = sysref_event & proc_en;
	wire sysref_ctl_t live_ctl = '{recv_en: recv_en, proc_en: proc_en,
		zoom: clock_control_q[`BIT_ZOOM], delay: clock_control_q[3:0]};

	always_ff @(posedge sys_clk) begin
		if (rst | soft_reset_q) begin
			direction_q <= `RST_DIRECTION;
			power_mode_q <= `RST_POWER_MODE;
			user_options_q <= `RST_USER_OPTIONS;
			clock_control_q <= `RST_CLOCK_CONTROL;
			addr_q <= '0;
			state_q <= ST_IDLE;
			rdata_q <= 8'h00;
			power_down_q <= 1'b0;
			applied_q <= '0;
			capture_q <= 1'b0;
		end else begin
			direction_q <= direction_d;
			power_mode_q <= power_mode_d;
			user_options_q <= user_options_d;
			clock_control_q <= clock_control_d;
			addr_q <= addr_d;
			state_q <= state_d;
			rdata_q <= req.rd ? rd_mux : rdata_q;
			power_down_q <= power_mode_q[1:0] == `MODE_POWER_DOWN;
			applied_q.recv_en <= recv_en;
			applied_q.proc_en <= proc_en;
			applied_q.zoom <= take_event ? live_ctl.zoom : applied_q.zoom;
			applied_q.delay <= take_event ? live_ctl.delay : applied_q.delay;
			capture_q <= take_event;
		end
	end

	// self-clearing soft reset, one cycle after the write
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			soft_reset_q <= 1'b0;
		end else begin
			soft_reset_q <= wr_dir & req.wdata[`BIT_RESET_REQ] & ~soft_reset_q;
		end
	end

	assign rdata = rdata_q;
	assign cur_addr = addr_q;
	assign power_down = power_down_q;
	assign applied_ctl = applied_q;
	assign sysref_capture = capture_q;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_frozen_byte;
		active && !req.start && freeze;
	endsequence

	sequence s_mode_reserved;
		(power_mode_q[1:0] == 2'h1 || power_mode_q[1:0] == 2'h2) ##1 !soft_reset_q;
	endsequence

	sequence s_first_byte;
		active && req.start && !soft_reset_q;
	endsequence

	a_mode_reserved_run: assert property (@(posedge sys_clk) disable iff (rst)
		s_mode_reserved |-> !power_down)
		else $error("power down raised for reserved mode");
	a_maker_high_fixed: assert property (@(posedge sys_clk) disable iff (rst)
		req.rd && eff_addr == 15'h000D && !soft_reset_q |=> rdata == 8'h5A)
		else $error("maker code high byte wrong");
	a_rdata_held: assert property (@(posedge sys_clk) disable iff (rst)
		!req.rd && !soft_reset_q |=> $stable(rdata))
		else $error("read byte changed without a read");
	a_edge_pos_low: assert property (@(posedge sys_clk) disable iff (rst)
		req.rd && eff_addr == 15'h002C && !soft_reset_q
		|=> rdata == $past(edge_position[7:0]))
		else $error("edge position low byte wrong");
	a_edge_pos_mid: assert property (@(posedge sys_clk) disable iff (rst)
		req.rd && eff_addr == 15'h002D && !soft_reset_q
		|=> rdata == $past(edge_position[15:8]))
		else $error("edge position middle byte wrong");
	a_edge_pos_top: assert property (@(posedge sys_clk) disable iff (rst)
		req.rd && eff_addr == 15'h002E && !soft_reset_q
		|=> rdata == $past(edge_position[23:16]))
		else $error("edge position top byte wrong");
	a_addr_start_taken: assert property (@(posedge sys_clk) disable iff (rst)
		s_first_byte |=> cur_addr == $past(req.addr))
		else $error("first byte address not taken");
	a_proc_enable_out: assert property (@(posedge sys_clk) disable iff (rst)
		!soft_reset_q |=> applied_ctl.proc_en == $past(clock_control_q[6] & clock_control_q[5]))
		else $error("processor enable not following bits 6 and 5");
	a_proc_needs_recv: assert property (@(posedge sys_clk) disable iff (rst)
		applied_ctl.proc_en |-> applied_ctl.recv_en)
		else $error("processor enabled without receiver");
	a_capture_taken: assert property (@(posedge sys_clk) disable iff (rst)
		take_event && !soft_reset_q |=> sysref_capture)
		else $error("taken event not captured");
	a_capture_single: assert property (@(posedge sys_clk) disable iff (rst)
		!take_event |=> !sysref_capture)
		else $error("capture without taken event");

	a_mode_power_down: assert property (@(posedge sys_clk) disable iff (rst)
		$past(!soft_reset_q) && !soft_reset_q && $past(power_mode_q[1:0]) == 2'h3
		|-> power_down)
		else $error("power down not raised for mode 3");
	a_mode_normal_run: assert property (@(posedge sys_clk) disable iff (rst)
		power_mode_q[1:0] == 2'h0 ##1 !soft_reset_q |-> !power_down)
		else $error("power down raised in normal mode");
	a_maker_read_fixed: assert property (@(posedge sys_clk) disable iff (rst)
		req.rd && eff_addr == 15'h000C && !soft_reset_q |=> rdata == 8'hA5)
		else $error("maker code low byte wrong");
	a_addr_hold_frozen: assert property (@(posedge sys_clk) disable iff (rst)
		s_frozen_byte ##0 !soft_reset_q |=> $stable(cur_addr))
		else $error("frozen address moved");
	a_addr_stream_up: assert property (@(posedge sys_clk) disable iff (rst)
		active && !req.start && !freeze && ascend && !soft_reset_q
		|=> cur_addr == $past(cur_addr) + 15'h0001)
		else $error("ascending address wrong");
	a_addr_stream_down: assert property (@(posedge sys_clk) disable iff (rst)
		active && !req.start && !freeze && !ascend && !soft_reset_q
		|=> cur_addr == $past(cur_addr) - 15'h0001)
		else $error("descending address wrong");
	a_recv_enable_out: assert property (@(posedge sys_clk) disable iff (rst)
		!soft_reset_q |=> applied_ctl.recv_en == $past(clock_control_q[5]))
		else $error("receiver enable not following bit 5");
	a_proc_event_gate: assert property (@(posedge sys_clk) disable iff (rst)
		sysref_event && !clock_control_q[6] |=> !sysref_capture)
		else $error("event captured while processor off");
	a_delay_on_event: assert property (@(posedge sys_clk) disable iff (rst)
		!take_event && !soft_reset_q |=> $stable(applied_ctl.delay)
		&& $stable(applied_ctl.zoom))
		else $error("delay changed without event");
	a_delay_taken: assert property (@(posedge sys_clk) disable iff (rst)
		take_event && !soft_reset_q |=> applied_ctl.delay == $past(clock_control_q[3:0])
		&& applied_ctl.zoom == $past(clock_control_q[4]))
		else $error("delay or zoom not taken on event");

endmodule // cfg_sysref_regs

/* File: test/cfg_host_model.sv */
// serial host model: one byte request per cycle into the register bank
// assumes the caller enters each transfer just after a rising edge of sys_clk
`timescale 1ns/1ps

module cfg_host_model
	import cfg_sysref_pkg::*;
(
	input wire logic sys_clk,
	output reg_req_t req
);
	initial req = '0;

	task automatic xfer(input logic [14:0] addr, input logic [7:0] wdata, input logic wr,
		input int n);
		for (int i = 0; i < n; i++) begin
			req = '{addr: addr, wdata: wdata, wr: wr, rd: !wr, start: i == 0};
			@(posedge sys_clk);
			#2;
		end
		// released lines show the inverse, never a stale copy
		req = '{addr: ~addr, wdata: ~wdata, wr: 1'b0, rd: 1'b0, start: 1'b1};
		@(posedge sys_clk);
		#2;
	endtask
endmodule // cfg_host_model

/* File: test/cfg_sysref_regs_tb.sv */
// self-checking bench for the configuration bank
// assumes the host model above; expected bytes and captures queue up for the watcher
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin num_errors++; \
	$display("[ERR] %s exp %h got %h", n, e, s); end end

module cfg_sysref_regs_tb
	import cfg_sysref_pkg::*;
;
	logic sys_clk, rst, sysref_event, power_down, sysref_capture, was_rd;
	logic [23:0] edge_position, pos;
	logic [7:0] rdata, exp_b;
	sysref_ctl_t exp_c;
	logic [14:0] cur_addr;
	logic [3:0] sel;
	reg_req_t req;
	sysref_ctl_t applied_ctl;
	int num_errors = 0;
	int compares = 0;
	integer seed = 32'h9dfb_8736;
	logic [7:0] exp_q[$];
	sysref_ctl_t cap_q[$];

	cfg_host_model cfg_host_model_i (.sys_clk(sys_clk), .req(req));
	cfg_sysref_regs cfg_sysref_regs_i (.sys_clk(sys_clk), .rst(rst), .req(req),
		.sysref_event(sysref_event), .edge_position(edge_position), .rdata(rdata),
		.cur_addr(cur_addr), .power_down(power_down), .applied_ctl(applied_ctl),
		.sysref_capture(sysref_capture));

	////////////////////////////////////////////////////////////////////////////////
	task automatic rd(input logic [14:0] a, input int n, input logic [23:0] e);
		for (int i = 0; i < n; i++) exp_q.push_back(e[8*i +: 8]);
		cfg_host_model_i.xfer(a, 8'h00, 1'b0, n);
	endtask

	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		cfg_host_model_i.xfer(a, d, 1'b1, 1);
	endtask

	task automatic pulse;
		sysref_event = 1'b1;
		@(posedge sys_clk);
		#2;
		sysref_event = 1'b0;
		repeat (2) @(posedge sys_clk);
		#2;
	endtask

	task tally_and_finish;
		if (num_errors == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// results show one edge after the request, so look just past each edge
	initial forever begin
		@(posedge sys_clk);
		was_rd = req.rd;
		#1;
		if (was_rd === 1'b1) begin
			exp_b = exp_q.pop_front();
			`CHK("rdata", exp_b, rdata)
		end
		if (sysref_capture === 1'b1) begin
			exp_c = cap_q.pop_front();
			`CHK("applied_ctl", exp_c, applied_ctl)
		end
	end

	initial begin
		#(2000 * 100);
		num_errors++;
		tally_and_finish();
	end

	initial begin
		rst = 1'b1;
		sysref_event = 1'b0;
		edge_position = 24'h00_0000;
		repeat (5) @(posedge sys_clk);
		#2;
		rst = 1'b0;
		rd(15'h0000, 3, 24'h00_0030);
		rd(15'h0010, 1, 24'h00_0000);
		rd(15'h0029, 1, 24'h00_0080);
		wr(15'h000c, 8'hff);
		rd(15'h000c, 2, 24'h00_5aa5);
		pos = 24'($random(seed));
		edge_position = pos;
		rd(15'h002c, 3, pos);
		wr(15'h0000, 8'h00);
		rd(15'h002e, 3, {pos[7:0], pos[15:8], pos[23:16]});
		`CHK("cur_addr", 15'h002c, cur_addr)
		wr(15'h0010, 8'h01);
		rd(15'h000c, 3, 24'ha5_a5a5);
		`CHK("cur_addr", 15'h000c, cur_addr)
		wr(15'h0010, 8'h00);
		wr(15'h0000, 8'h20);
		wr(15'h0002, 8'h03);
		`CHK("power_down", 1'b1, power_down)
		wr(15'h0002, 8'h02);
		`CHK("power_down", 1'b0, power_down)
		wr(15'h0002, 8'h00);
		`CHK("power_down", 1'b0, power_down)
		pulse();
		wr(15'h0029, 8'ha0);
		`CHK("recv_en", 1'b1, applied_ctl.recv_en)
		`CHK("proc_en", 1'b0, applied_ctl.proc_en)
		pulse();
		sel = 4'($random(seed));
		wr(15'h0029, {4'b1111, sel});
		cap_q.push_back('{recv_en: 1'b1, proc_en: 1'b1, zoom: 1'b1, delay: sel});
		pulse();
		wr(15'h0029, {4'b1110, ~sel});
		`CHK("held delay", sel, applied_ctl.delay)
		cap_q.push_back('{recv_en: 1'b1, proc_en: 1'b1, zoom: 1'b0, delay: ~sel});
		pulse();
		// soft reset needs one quiet cycle after the write; the release cycle gives it, two more follow
		wr(15'h0000, 8'hb0);
		repeat (2) @(posedge sys_clk);
		#2;
		rd(15'h0029, 1, 24'h00_0080);
		rd(15'h0000, 1, 24'h00_0030);
		`CHK("recv_en", 1'b0, applied_ctl.recv_en)
		repeat (3) @(posedge sys_clk);
		`CHK("pending", 0, exp_q.size() + cap_q.size())
		tally_and_finish();
	end
endmodule // cfg_sysref_regs_tb
